// *** inc/ssbrg_pkg.sv ***
// Package for the serial status flags and bit-rate generator block.
// Assumes a Wishbone classic slave with 32-bit data, registers in the low byte except the write-only transmit-end interrupt enable at control bit 8.
package ssbrg_pkg;
    // Register byte addresses
    localparam logic [3:0] ADDR_STATUS  = 4'h0;
    localparam logic [3:0] ADDR_DIVISOR = 4'h4;
    localparam logic [3:0] ADDR_CONTROL = 4'h8;
    // Status register bit positions
    localparam int BIT_TDE  = 7;
    localparam int BIT_RDF  = 6;
    localparam int BIT_OVR  = 5;
    localparam int BIT_FRM  = 4;
    localparam int BIT_PAR  = 3;
    localparam int BIT_TX_END_FLAG = 2;
    localparam int BIT_RMPB = 1;
    localparam int BIT_TMPB = 0;
    // Control register bit positions
    localparam int BIT_TXEN = 0;
    localparam int BIT_RXEN = 1;
    localparam int BIT_SYNC = 2;
    localparam int BIT_MPEN = 3;
    localparam int BIT_PEN  = 4;
    localparam int BIT_ODD  = 5;
    localparam int BIT_CKS  = 6;
    // Reset values
    localparam logic [7:0] STATUS_RST  = 8'h84;
    localparam logic [7:0] DIVISOR_RST = 8'hFF;
    localparam logic [7:0] CONTROL_RST = 8'h00;
    // Generator constants
    localparam int ASYNC_FACTOR = 64;
    localparam int SYNC_FACTOR  = 8;
    localparam int OVERSAMPLE   = 16;
    localparam int SAMPLE_POINT = 8;
    // Prescaler select codes
    typedef enum logic [1:0] {
        SSBRG_CK_SYS   = 2'b00,
        SSBRG_CK_DIV4  = 2'b01,
        SSBRG_CK_DIV16 = 2'b10,
        SSBRG_CK_DIV64 = 2'b11
    } ssbrg_cks_t;
endpackage

// *** inc/ssbrg_gen_if.sv ***
// Interface between the register logic and the bit-rate generator.
// Assumes both ends sit on i_mclk.
`timescale 1ns/100ps
interface ssbrg_gen_if;
    logic [7:0] divisor;
    logic [1:0] cks;
    logic       sync_mode;
    logic       run;
    logic       tick16;
    logic       bit_tick;
    modport ctrl (output divisor, cks, sync_mode, run, input tick16, bit_tick);
    modport gen  (input divisor, cks, sync_mode, run, output tick16, bit_tick);
endinterface

// *** verilog/ssbrg_rate_gen.sv ***
// Bit-rate generator: prescaler then divisor counter.
// Assumes one clock; the system clock stands in for the peripheral clock.
`timescale 1ns/100ps
module ssbrg_rate_gen (
    // Clock and reset
    input  wire logic   i_mclk,
    input  wire logic   i_rst_n,
    // Control and ticks
    ssbrg_gen_if.gen    gen
);
    logic [5:0] pre_r;
    logic [7:0] div_r;
    logic [4:0] sub_r;
    logic       pre_tick;
    logic       div_tick;

    // Period of the prescaler is 1, 4, 16 or 64 (2^(2n)); one more factor of two sits below
    always_comb begin
        unique case (ssbrg_pkg::ssbrg_cks_t'(gen.cks))
            ssbrg_pkg::SSBRG_CK_SYS:   pre_tick = 1'b1;
            ssbrg_pkg::SSBRG_CK_DIV4:  pre_tick = (pre_r[1:0] == 2'h3);
            ssbrg_pkg::SSBRG_CK_DIV16: pre_tick = (pre_r[3:0] == 4'hF);
            ssbrg_pkg::SSBRG_CK_DIV64: pre_tick = (pre_r == 6'h3F);
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pre_r <= 6'h00;
        end else if (!gen.run) begin
            pre_r <= 6'h00;
        end else begin
            pre_r <= pre_r + 6'h01;
        end
    end

    // Divide by N+1 over the full 0..255 span
    assign div_tick = pre_tick && (div_r == 8'h00);
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            div_r <= 8'h00;
        end else if (!gen.run) begin
            div_r <= gen.divisor;
        end else if (pre_tick) begin
            div_r <= (div_r == 8'h00) ? gen.divisor : div_r - 8'h01;
        end
    end

    // Base tick is F/(2^(2n)*(N+1)); tick16 is every second base tick
    // Async: bit = 32 base ticks = 16 tick16; sync: bit = 4 base ticks
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sub_r       <= 5'h00;
            gen.tick16  <= 1'b0;
            gen.bit_tick <= 1'b0;
        end else begin
            gen.tick16   <= 1'b0;
            gen.bit_tick <= 1'b0;
            if (!gen.run) begin
                sub_r <= 5'h00;
            end else if (div_tick) begin
                sub_r      <= sub_r + 5'h01;
                gen.tick16 <= sub_r[0];
                if (gen.sync_mode) begin
                    gen.bit_tick <= (sub_r[1:0] == 2'h3);
                end else begin
                    gen.bit_tick <= (sub_r == 5'h1F);
                end
            end
        end
    end
endmodule // ssbrg_rate_gen

// *** verilog/ssbrg_top.sv ***
// Status flags, divisor register and bit-rate generator of the serial interface.
// Assumes the shift datapaths report events as one-cycle pulses on i_mclk.
// Overview of operation
// - Transmit-empty sets on holding-to-shift transfer and when transmit enable clears.
// - Status flags clear only by read as 1 then write 0; writing 1 ignored.
// - Receive-full sets when an error-free character moves to the receive holding register.
// - Overrun sets when another character completes while receive-full is still 1.
// - Framing error sets on a 0 stop bit, asynchronous mode only.
// - Parity error sets on parity mismatch in asynchronous parity formats only.
// - Transmit-end sets when transmit disabled or empty at last bit sent.
// - Transmit-end is read-only; cleared by the transmit-empty read-then-write-0 sequence.
// - Received multiprocessor bit captured in multiprocessor async receive; else holds; read-only.
// - Transmit multiprocessor bit double-buffered with holding and shift registers.
// - Transmit multiprocessor bit has no effect in sync or non-multiprocessor formats.
// - Divisor register resets and enters standby as all ones.
// - Async bit rate is F/(64*2^(2n-1)*(N+1)).
// - Divisor N spans 0 to 255 unsigned.
// - Clock select picks system clock or prescaled by 4, 16, 64.
// - Sync bit rate is F/(8*2^(2n-1)*(N+1)).
// - Async receiver runs at 16x bit rate, samples at eighth cycle after start edge.
`timescale 1ns/100ps
module ssbrg_top (
    // Clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_rst_n,
    input  wire logic        i_standby,
    // Wishbone classic slave
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [3:0]  i_wb_adr,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic [31:0] i_wb_dat,
    output logic      [31:0] o_wb_dat,
    output logic             o_wb_ack,
    // Datapath events
    input  wire logic        i_tx_load,
    input  wire logic        i_tx_last_bit,
    input  wire logic        i_rx_done,
    input  wire logic        i_rx_stop_bit,
    input  wire logic        i_rx_parity_bad,
    input  wire logic        i_rx_mpb,
    input  wire logic        i_rx_start_edge,
    // Control and timing outputs
    output logic             o_tx_enable,
    output logic             o_rx_enable,
    output logic             o_tx_mpb_send,
    output logic             o_rx_load,
    output logic             o_rx_sample,
    output logic             o_bit_tick,
    output logic             o_tx_end_irq
);
    logic [7:0] status_r;
    logic [7:0] divisor_r;
    logic [7:0] control_r;
    logic [6:0] seen_one_r;
    logic       tx_mpb_shift_r;
    logic [3:0] rx_phase_r;
    logic       rx_hunt_r;
    logic       tx_end_irq_en_r;
    logic       wr_acc;
    logic       rd_acc;
    logic       st_wr;
    logic       async_mode;
    logic       mp_fmt;
    logic       par_fmt;
    logic       rx_ok;
    logic       tx_en_fall;
    logic [7:0] rd_data;

    ssbrg_gen_if gif ();

    ssbrg_rate_gen u_gen (
        .i_mclk  (i_mclk),
        .i_rst_n (i_rst_n),
        .gen     (gif.gen)
    );

    assign gif.divisor   = divisor_r;
    assign gif.cks       = control_r[ssbrg_pkg::BIT_CKS +: 2];
    assign gif.sync_mode = control_r[ssbrg_pkg::BIT_SYNC];
    assign gif.run       = control_r[ssbrg_pkg::BIT_TXEN] | control_r[ssbrg_pkg::BIT_RXEN];

    assign async_mode = !control_r[ssbrg_pkg::BIT_SYNC];
    assign mp_fmt     = async_mode && control_r[ssbrg_pkg::BIT_MPEN];
    assign par_fmt    = async_mode && !mp_fmt && control_r[ssbrg_pkg::BIT_PEN];
    assign rx_ok      = i_rx_done && control_r[ssbrg_pkg::BIT_RXEN];

    // Bus decode; ack stands one cycle and drops before the next request
    assign wr_acc = i_wb_cyc && i_wb_stb && !o_wb_ack && i_wb_we && i_wb_sel[0];
    assign rd_acc = i_wb_cyc && i_wb_stb && !o_wb_ack && !i_wb_we;
    assign st_wr  = wr_acc && (i_wb_adr == ssbrg_pkg::ADDR_STATUS);

    always_comb begin
        rd_data = 8'h00;
        unique case (i_wb_adr)
            ssbrg_pkg::ADDR_STATUS:  rd_data = status_r;
            ssbrg_pkg::ADDR_DIVISOR: rd_data = divisor_r;
            ssbrg_pkg::ADDR_CONTROL: rd_data = control_r;
            default:                 rd_data = 8'h00;
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h0000_0000;
        end else begin
            o_wb_ack <= i_wb_cyc && i_wb_stb && !o_wb_ack;
            if (rd_acc) begin
                o_wb_dat <= {24'h00_0000, rd_data};
            end
        end
    end

    // Control register: mode bits, enables, clock select; cleared in standby
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            control_r       <= ssbrg_pkg::CONTROL_RST;
            tx_end_irq_en_r <= 1'b0;
        end else if (i_standby) begin
            control_r       <= ssbrg_pkg::CONTROL_RST;
            tx_end_irq_en_r <= 1'b0;
        end else if (wr_acc && i_wb_adr == ssbrg_pkg::ADDR_CONTROL) begin
            control_r <= i_wb_dat[7:0];
            if (i_wb_sel[1]) begin
                tx_end_irq_en_r <= i_wb_dat[8];
            end
        end
    end

    assign tx_en_fall = control_r[ssbrg_pkg::BIT_TXEN]
                        && (i_standby
                            || (wr_acc && i_wb_adr == ssbrg_pkg::ADDR_CONTROL
                                && !i_wb_dat[ssbrg_pkg::BIT_TXEN]));

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            divisor_r <= ssbrg_pkg::DIVISOR_RST;
        end else if (i_standby) begin
            divisor_r <= ssbrg_pkg::DIVISOR_RST;
        end else if (wr_acc && i_wb_adr == ssbrg_pkg::ADDR_DIVISOR) begin
            divisor_r <= i_wb_dat[7:0];
        end
    end

    // Remember which flags software has seen as 1 since the last clear
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            seen_one_r <= 7'h00;
        end else if (i_standby) begin
            seen_one_r <= 7'h00;
        end else if (rd_acc && i_wb_adr == ssbrg_pkg::ADDR_STATUS) begin
            seen_one_r <= seen_one_r | status_r[7:1];
        end else if (st_wr) begin
            seen_one_r <= seen_one_r & i_wb_dat[7:1];
        end
    end

    // Flags: clear first, then hardware sets win
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            status_r <= ssbrg_pkg::STATUS_RST;
        end else if (i_standby) begin
            status_r <= ssbrg_pkg::STATUS_RST;
        end else begin
            if (st_wr) begin
                for (int b = ssbrg_pkg::BIT_PAR; b <= ssbrg_pkg::BIT_TDE; b++) begin
                    if (!i_wb_dat[b] && seen_one_r[b-1]) begin
                        status_r[b] <= 1'b0;
                    end
                end
                if (!i_wb_dat[ssbrg_pkg::BIT_TDE] && seen_one_r[ssbrg_pkg::BIT_TDE-1]) begin
                    status_r[ssbrg_pkg::BIT_TX_END_FLAG] <= 1'b0;
                end
                status_r[ssbrg_pkg::BIT_TMPB] <= i_wb_dat[ssbrg_pkg::BIT_TMPB];
            end
            if (i_tx_load || tx_en_fall) begin
                status_r[ssbrg_pkg::BIT_TDE] <= 1'b1;
            end
            if (!control_r[ssbrg_pkg::BIT_TXEN]
                || (i_tx_last_bit && status_r[ssbrg_pkg::BIT_TDE])) begin
                status_r[ssbrg_pkg::BIT_TX_END_FLAG] <= 1'b1;
            end
            if (rx_ok) begin
                if (status_r[ssbrg_pkg::BIT_RDF]) begin
                    status_r[ssbrg_pkg::BIT_OVR] <= 1'b1;
                end else if (async_mode && !i_rx_stop_bit) begin
                    status_r[ssbrg_pkg::BIT_FRM] <= 1'b1;
                end else if (par_fmt && i_rx_parity_bad) begin
                    status_r[ssbrg_pkg::BIT_PAR] <= 1'b1;
                end else begin
                    status_r[ssbrg_pkg::BIT_RDF] <= 1'b1;
                end
                if (mp_fmt) begin
                    status_r[ssbrg_pkg::BIT_RMPB] <= i_rx_mpb;
                end
            end
        end
    end

    // Second stage of the multiprocessor bit, loaded with the character
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tx_mpb_shift_r <= 1'b0;
        end else if (i_tx_load) begin
            tx_mpb_shift_r <= status_r[ssbrg_pkg::BIT_TMPB];
        end
    end

    // Receive sampling: hunt for start edge, then sample at phase 8 of 16
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rx_phase_r  <= 4'h0;
            rx_hunt_r   <= 1'b1;
            o_rx_sample <= 1'b0;
        end else begin
            o_rx_sample <= 1'b0;
            if (!control_r[ssbrg_pkg::BIT_RXEN] || !async_mode || i_rx_done) begin
                rx_hunt_r  <= 1'b1;
                rx_phase_r <= 4'h0;
            end else if (rx_hunt_r && i_rx_start_edge) begin
                rx_hunt_r  <= 1'b0;
                rx_phase_r <= 4'h0;
            end else if (!rx_hunt_r && gif.tick16) begin
                rx_phase_r  <= rx_phase_r + 4'h1;
                o_rx_sample <= (rx_phase_r == 4'(ssbrg_pkg::SAMPLE_POINT - 1));
            end
        end
    end

    // Registered outputs
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_tx_enable   <= 1'b0;
            o_rx_enable   <= 1'b0;
            o_tx_mpb_send <= 1'b0;
            o_rx_load     <= 1'b0;
            o_bit_tick    <= 1'b0;
            o_tx_end_irq  <= 1'b0;
        end else begin
            o_tx_enable   <= control_r[ssbrg_pkg::BIT_TXEN];
            o_rx_enable   <= control_r[ssbrg_pkg::BIT_RXEN];
            o_tx_mpb_send <= mp_fmt && tx_mpb_shift_r;
            o_rx_load     <= rx_ok && !status_r[ssbrg_pkg::BIT_RDF];
            o_bit_tick    <= gif.bit_tick;
            o_tx_end_irq  <= tx_end_irq_en_r && status_r[ssbrg_pkg::BIT_TX_END_FLAG];
        end
    end
endmodule // ssbrg_top

// *** verif/ssbrg_top_asserts.sv ***
// Port checker for ssbrg_top; bound by the line after endmodule.
// Assumes one clock domain and an asynchronous active-low reset.
`timescale 1ns/100ps
module ssbrg_top_asserts (
    // Clock and reset
    input wire logic        i_mclk,
    input wire logic        i_rst_n,
    // Watched ports
    input wire logic        i_standby,
    input wire logic        i_wb_stb,
    input wire logic [31:0] o_wb_dat,
    input wire logic        o_wb_ack,
    input wire logic        i_rx_done,
    input wire logic        o_tx_enable,
    input wire logic        o_rx_enable,
    input wire logic        o_rx_load,
    input wire logic        o_rx_sample,
    input wire logic        o_bit_tick
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    wire idle = !o_tx_enable && !o_rx_enable;
    ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack) else $error("long ack");
    ack_due_a: assert property (i_wb_stb && !o_wb_ack |=> o_wb_ack) else $error("no ack");
    ack_idle_a: assert property (!i_wb_stb |=> !o_wb_ack) else $error("stray ack");
    rd_upper_a: assert property (o_wb_ack |-> o_wb_dat[31:8] == 24'h00_0000)
        else $error("upper read bits set");
    rx_load_a: assert property (o_rx_load |-> $past(i_rx_done) && $past(o_rx_enable))
        else $error("load without done");
    standby_a: assert property (i_standby [*2] |=> idle) else $error("standby kept enables");
    gen_idle_a: assert property (idle [*3] |=> !o_bit_tick && !o_rx_sample)
        else $error("ticks while stopped");
    tick_gap_a: assert property (o_bit_tick |=> !o_bit_tick [*3]) else $error("short bit");
    load_c: cover property (o_rx_load);
    tick_c: cover property (o_bit_tick);
    sample_c: cover property (o_rx_sample);
endmodule // ssbrg_top_asserts
bind ssbrg_top ssbrg_top_asserts ssbrg_top_asserts_inst (.i_mclk, .i_rst_n, .i_standby,
    .i_wb_stb, .o_wb_dat, .o_wb_ack, .i_rx_done, .o_tx_enable, .o_rx_enable, .o_rx_load,
    .o_rx_sample, .o_bit_tick);

// *** verif/ssbrg_remote_stn.sv ***
// Remote serial station: hands received characters over as datapath events.
// Assumes one-cycle send requests from the bench and a delay of at least 2.
`timescale 1ns/100ps
module ssbrg_remote_stn (
    // Clock
    input  wire logic       i_mclk,
    // Character request: {stop, parity bad, mp bit}
    input  wire logic       i_send,
    input  wire logic [2:0] i_chr,
    input  wire logic [7:0] i_delay,
    // Datapath events
    output logic            o_start_edge,
    output logic            o_done,
    output logic            o_stop,
    output logic            o_par_bad,
    output logic            o_mpb,
    output logic            o_busy
);
    logic [7:0] cnt_r = 8'h00;
    logic [2:0] chr_r = 3'b000;
    initial {o_start_edge, o_done, o_stop, o_par_bad, o_mpb, o_busy} = 6'h00;
    always @(posedge i_mclk) begin
        o_start_edge <= i_send;
        o_done <= (cnt_r == 8'h01);
        if (i_send) begin
            {chr_r, cnt_r, o_busy} <= {i_chr, i_delay, 1'b1};
        end else if (cnt_r != 8'h00) begin
            cnt_r <= cnt_r - 8'h01;
        end else begin
            o_busy <= 1'b0;
        end
        // Levels flip outside the done pulse so a stale value never looks fresh
        if (cnt_r == 8'h01) {o_stop, o_par_bad, o_mpb} <= chr_r;
        else {o_stop, o_par_bad, o_mpb} <= ~{o_stop, o_par_bad, o_mpb};
    end
endmodule // ssbrg_remote_stn

// *** verif/tb.sv ***
// Bench for ssbrg_top: register bus, status flags, rate generator.
// Assumes the station model and the checker bind are compiled first.
`timescale 1ns/100ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin failures++; \
    $display("ERROR %0t mismatch", $time); end end
module tb;
    logic        i_mclk = 1'b0;
    logic        i_rst_n = 1'b0;
    logic        i_standby = 1'b0;
    logic        i_wb_cyc = 1'b0;
    logic        i_wb_stb = 1'b0;
    logic        i_wb_we = 1'b0;
    logic [3:0]  i_wb_adr = 4'h0;
    logic [3:0]  i_wb_sel = 4'h0;
    logic [31:0] i_wb_dat = 32'h0000_0000;
    logic        i_tx_load = 1'b0;
    logic        i_tx_last_bit = 1'b0;
    logic        send = 1'b0;
    logic [2:0]  chr = 3'h0;
    logic [7:0]  dly = 8'h02;
    logic [31:0] o_wb_dat;
    logic        o_wb_ack, o_tx_enable, o_tx_mpb_send, o_bit_tick;
    logic        rx_go, rx_done, rx_stop, rx_par, rx_mpb, busy;
    logic        rx_load, rx_sample, tx_irq;
    logic [7:0]  exp_q[$];
    int          failures = 0;
    int          comparisons = 0;
    int          loads = 0;
    int          samples = 0;
    always #5 i_mclk = ~i_mclk;
    ssbrg_top ssbrg_top_inst (.i_mclk, .i_rst_n, .i_standby, .i_wb_cyc, .i_wb_stb, .i_wb_we,
        .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack, .i_tx_load, .i_tx_last_bit,
        .i_rx_done(rx_done), .i_rx_stop_bit(rx_stop), .i_rx_parity_bad(rx_par),
        .i_rx_mpb(rx_mpb), .i_rx_start_edge(rx_go), .o_tx_enable, .o_rx_enable(),
        .o_tx_mpb_send, .o_rx_load(rx_load), .o_rx_sample(rx_sample), .o_bit_tick,
        .o_tx_end_irq(tx_irq));
    ssbrg_remote_stn ssbrg_remote_stn_inst (.i_mclk, .i_send(send), .i_chr(chr),
        .i_delay(dly), .o_start_edge(rx_go), .o_done(rx_done), .o_stop(rx_stop),
        .o_par_bad(rx_par), .o_mpb(rx_mpb), .o_busy(busy));
    // Read data is taken only at the ack edge, oldest note first
    always @(posedge i_mclk) begin
        if (rx_load === 1'b1) loads++;
        if (rx_sample === 1'b1) samples++;
        if (o_wb_ack === 1'b1 && i_wb_we === 1'b0 && exp_q.size() > 0) begin
            `CHK(o_wb_dat, {24'h00_0000, exp_q.pop_front()})
        end
    end
    task automatic complete_run();
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic guard(input bit hit);
        if (hit) begin
            failures++;
            complete_run();
        end
    endtask
    task automatic cyc(input logic [3:0] a, input logic we, input logic [31:0] d,
                       input logic [3:0] s);
        int n;
        n = 0;
        {i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_dat, i_wb_sel} <= {2'b11, we, a, d, s};
        do begin
            @(posedge i_mclk);
            n++;
        end while (o_wb_ack !== 1'b1 && n < 50);
        {i_wb_cyc, i_wb_stb} <= 2'b00;
        guard(n >= 50);
        @(posedge i_mclk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        cyc(a, 1'b0, 32'h0000_0000, 4'hF);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        cyc(a, 1'b1, {24'h00_0000, d}, 4'hF);
    endtask
    task automatic tx_ev(input logic last);
        {i_tx_last_bit, i_tx_load} <= {last, !last};
        @(posedge i_mclk);
        {i_tx_last_bit, i_tx_load} <= 2'b00;
        repeat (3) @(posedge i_mclk);
    endtask
    task automatic rx(input logic [2:0] c);
        int n;
        n = 0;
        {send, chr, dly} <= {1'b1, c, 8'($urandom_range(33, 2))};
        @(posedge i_mclk);
        send <= 1'b0;
        do begin
            @(posedge i_mclk);
            n++;
        end while (busy !== 1'b0 && n < 60);
        guard(n >= 60);
        repeat (3) @(posedge i_mclk);
    endtask
    // Stop first so the measured interval starts from a clean prescaler
    task automatic rate(input logic [1:0] n, input logic s, input logic [7:0] d);
        int k;
        int p;
        wr(4'h8, 8'h00);
        wr(4'h4, d);
        wr(4'h8, {n, 3'b000, s, 2'b01});
        k = 0;
        while (o_bit_tick !== 1'b1 && k < 9000) begin
            @(posedge i_mclk);
            k++;
        end
        p = 0;
        do begin
            @(posedge i_mclk);
            p++;
        end while (o_bit_tick !== 1'b1 && p < 9000);
        guard(k >= 9000);
        `CHK(p, (s ? 4 : 32) * (1 << (2 * n)) * (d + 1))
    endtask
    initial begin
        void'($urandom(32'h0000_A9A9));
        repeat (20) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        @(posedge i_mclk);
        rd(4'h0, 8'h84);
        rd(4'h4, 8'hFF);
        rd(4'hC, 8'h00);
        wr(4'h4, 8'h5A);
        cyc(4'h4, 1'b1, 32'h0000_0000, 4'hE);
        rd(4'h4, 8'h5A);
        wr(4'h0, 8'hFE);
        rd(4'h0, 8'h84);
        wr(4'h8, 8'h09);
        wr(4'h0, 8'h00);
        rd(4'h0, 8'h00);
        wr(4'h0, 8'h01);
        tx_ev(1'b0);
        `CHK(o_tx_mpb_send, 1'b1)
        wr(4'h0, 8'h00);
        `CHK(o_tx_mpb_send, 1'b1)
        tx_ev(1'b1);
        rd(4'h0, 8'h84);
        wr(4'h8, 8'h05);
        wr(4'h0, 8'h81);
        tx_ev(1'b0);
        `CHK(o_tx_mpb_send, 1'b0)
        rd(4'h0, 8'h85);
        wr(4'h0, 8'h00);
        // The status write of 0 after reading it as 1 already cleared the end flag before the interrupt is enabled
        cyc(4'h8, 1'b1, 32'h0000_0105, 4'hF);
        tx_ev(1'b1);
        `CHK(tx_irq, 1'b0)
        tx_ev(1'b0);
        tx_ev(1'b1);
        `CHK(tx_irq, 1'b1)
        wr(4'h8, 8'h00);
        rd(4'h0, 8'h84);
        wr(4'h8, 8'h0A);
        rx(3'b101);
        wr(4'h0, 8'h80);
        rd(4'h0, 8'hC6);
        rx(3'b101);
        rd(4'h0, 8'hE6);
        wr(4'h0, 8'h80);
        rd(4'h0, 8'h86);
        wr(4'h8, 8'h12);
        rx(3'b000);
        rd(4'h0, 8'h96);
        rx(3'b110);
        rd(4'h0, 8'h9E);
        wr(4'h0, 8'h80);
        wr(4'h8, 8'h00);
        rx(3'b100);
        rd(4'h0, 8'h86);
        wr(4'h8, 8'h06);
        rx(3'b000);
        rd(4'h0, 8'hC6);
        // Fast oversampling clock so two sample points fall inside one long character
        wr(4'h8, 8'h00);
        wr(4'h4, 8'h00);
        wr(4'h8, 8'h02);
        {send, dly} <= {1'b1, 8'h3C};
        @(posedge i_mclk);
        send <= 1'b0;
        repeat (70) @(posedge i_mclk);
        `CHK(samples, 2)
        `CHK(loads, 4)
        for (int i = 0; i < 4; i++) begin
            rate(2'(i), 1'b0, 8'($urandom_range(2, 0)));
            rate(2'(i), 1'b1, 8'($urandom_range(2, 0)));
        end
        rate(2'b00, 1'b0, 8'hFF);
        i_standby <= 1'b1;
        repeat (2) @(posedge i_mclk);
        i_standby <= 1'b0;
        @(posedge i_mclk);
        rd(4'h0, 8'h84);
        rd(4'h4, 8'hFF);
        complete_run();
    end
endmodule // tb
